// ---- src/tw_pkg.sv ----
/*
 * tw_pkg: offsets, field positions, reset values, timing and carrier types
 * for the timer / watchdog / interrupt mask block.
 * Assumes a 25 MHz APB clock and one aligned 32-bit word per register.
 */
package tw_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_TIMER_IRQ_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_WATCHDOG_CONTROL   = 8'h04;
  localparam logic [7:0] OFS_INTERRUPT_MASK_TWO = 8'h08;
  localparam logic [7:0] OFS_INTERRUPT_MASK_ONE = 8'h0C;
  localparam logic [7:0] OFS_MAIN_TIMER         = 8'h10;
  localparam logic [7:0] OFS_IRQ_FLAGS          = 8'h14;
  // timer_irq_control fields
  localparam int CTL_EXT_EDGE = 7;
  localparam int CTL_GIE      = 6;
  localparam int CTL_SRC      = 5;
  localparam int CTL_TEDGE    = 4;
  localparam int CTL_PEN      = 3;
  // watchdog_control fields
  localparam int WDC_EN       = 7;
  localparam int WDC_PINSEL   = 6;
  localparam int WDC_PEN      = 3;
  // flag / combined mask positions
  localparam int FLG_COMP     = 7;
  localparam int FLG_ADC      = 6;
  localparam int FLG_T3       = 5;
  localparam int FLG_T2       = 4;
  localparam int FLG_EXT      = 2;
  localparam int FLG_PCHG     = 1;
  localparam int FLG_TIMER    = 0;
  // writable bit masks, reset byte and timer maximum
  localparam logic [7:0] CTL_WMASK  = 8'hBF;
  localparam logic [7:0] WDC_WMASK  = 8'hCF;
  localparam logic [7:0] MSK2_WMASK = 8'h30;
  localparam logic [7:0] MSK1_WMASK = 8'hC7;
  localparam logic [7:0] RST_BYTE   = 8'h00;
  localparam logic [7:0] TIMER_MAX  = 8'hFF;
  // timing
  localparam int PCLK_PERIOD_NS    = 40;
  localparam int WDOG_TIMEOUT_NS   = 18_000_000;
  localparam int WDOG_TIMEOUT_CYC  = WDOG_TIMEOUT_NS / PCLK_PERIOD_NS;
  localparam int WDOG_CNT_W        = 20;

  typedef struct packed {
    logic irq_on_instr;
    logic irq_off_instr;
    logic irq_return_instr;
    logic irq_entry;
    logic wdog_clear_instr;
    logic sleep_instr;
  } tw_core_instr_type;

  typedef struct packed {
    logic comparator_irq_flag;
    logic adc_done_irq_flag;
    logic timer3_irq_flag;
    logic timer2_irq_flag;
    logic pin_change_irq_flag;
  } tw_event_type;
endpackage : tw_pkg

// ---- src/tw_timer_wdog.sv ----
/*
 * tw_timer_wdog: 8-bit main timer with prescaler, watchdog with prescaler,
 * external interrupt edge logic, interrupt flags and masks, APB slave.
 * Assumes pins, instructions and event pulses are synchronous to pclk;
 * the watchdog oscillator is modelled by pclk itself.
 */
// The APB register port and the address map were left to the implementer.
// How it works
// R1: ext irq edge bit: 0 rising, 1 falling
// R2: global enable cleared by off/entry, set by on/return
// R3: source bit picks cycle clock or timer pin
// R4: pin edge bit picks rising or falling count
// R5: timer prescaler off gives 1:1 rate
// R6: timer ratio code n divides by 2^(n+1)
// R7: watchdog enable bit freely written by software
// R8: pin select 0 masks ext irq; 1 readable
// R9: software sets pin direction to input
// R10: watchdog prescaler off gives 1:1 rate
// R11: watchdog ratio code n divides by 2^(n+1)
// R12: mask two: timer3 bit5, timer2 bit4
// R13: mask one enables comparator, adc, ext, change, timer
// R14: two separate 8-bit prescaler counters
// R15: timer write clears timer prescaler
// R16: clear or sleep instruction clears watchdog and prescaler
// R17: 8-bit timer, one per core cycle unprescaled
// R18: external pin levels last over one clock
// R19: timer stops while sleeping
// R20: enabled watchdog timeout resets device, even asleep
// R21: unprescaled watchdog timeout about 18 ms
// R22: timer wrap sets flag; request needs both enables
`timescale 1ns/1ps
module tw_timer_wdog
  import tw_pkg::*;
#(
  parameter logic [WDOG_CNT_W-1:0] WDOG_TIMEOUT = WDOG_CNT_W'(WDOG_TIMEOUT_CYC)
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire tw_core_instr_type instr,
  input  wire tw_event_type      events,
  input  wire logic              wake_req,
  input  wire logic              timer_pin,
  input  wire logic              ext_irq_shared_pin,
  output logic                   ext_pin_level,
  output logic                   irq_req,
  output logic                   wdog_reset,
  output logic                   sleeping
);

  function automatic logic prescale_tick(input logic [7:0] cnt, input logic en,
                                         input logic [2:0] ratio);
    logic [7:0] mask;
    mask = 8'((9'h002 << ratio) - 9'h001);
    prescale_tick = en ? ((cnt & mask) == mask) : 1'b1;
  endfunction : prescale_tick

  logic [7:0]            ctl_reg, ctl_next;
  logic [7:0]            wdc_reg, wdc_next;
  logic [7:0]            msk2_reg, msk2_next;
  logic [7:0]            msk1_reg, msk1_next;
  logic [7:0]            timer_reg, timer_next;
  logic [7:0]            tpres_reg, tpres_next;
  logic [7:0]            wpres_reg, wpres_next;
  logic [WDOG_CNT_W-1:0] wcnt_reg, wcnt_next;
  logic [7:0]            flag_reg, flag_next;
  logic                  gie_reg, gie_next;
  logic                  tpin_prev_reg;
  logic                  epin_prev_reg;
  logic [31:0]           prdata_reg;
  logic                  pready_reg;
  logic                  pslverr_reg;
  logic                  irq_req_reg;
  logic                  wdog_reset_reg;
  logic                  sleep_reg;
  logic                  ext_level_reg;

  // bus decode
  wire logic       setup_ph  = psel & ~penable;
  wire logic       access_ph = psel & penable & pready_reg;
  wire logic       hit_ctl   = paddr == OFS_TIMER_IRQ_CONTROL;
  wire logic       hit_wdc   = paddr == OFS_WATCHDOG_CONTROL;
  wire logic       hit_msk2  = paddr == OFS_INTERRUPT_MASK_TWO;
  wire logic       hit_msk1  = paddr == OFS_INTERRUPT_MASK_ONE;
  wire logic       hit_tmr   = paddr == OFS_MAIN_TIMER;
  wire logic       hit_flg   = paddr == OFS_IRQ_FLAGS;
  wire logic       mapped    = hit_ctl | hit_wdc | hit_msk2 | hit_msk1 | hit_tmr | hit_flg;
  wire logic       wr        = access_ph & pwrite & mapped;
  wire logic [7:0] wbyte     = pwdata[7:0];
  wire logic [7:0] rbyte     = hit_ctl  ? {ctl_reg[7], gie_reg, ctl_reg[5:0]} :
                               hit_wdc  ? wdc_reg  :
                               hit_msk2 ? msk2_reg :
                               hit_msk1 ? msk1_reg :
                               hit_tmr  ? timer_reg :
                               hit_flg  ? flag_reg : RST_BYTE;

  // main timer source and prescaler
  wire logic tpin_rise  = timer_pin & ~tpin_prev_reg;
  wire logic tpin_fall  = ~timer_pin & tpin_prev_reg;
  wire logic tpin_edge  = ctl_reg[CTL_TEDGE] ? tpin_fall : tpin_rise;           // [R4]
  wire logic src_event  = ctl_reg[CTL_SRC] ? tpin_edge : 1'b1;                  // [R3] [R17]
  wire logic t_active   = src_event & ~sleep_reg;                               // [R19]
  wire logic t_step     = t_active &
                          prescale_tick(tpres_reg, ctl_reg[CTL_PEN], ctl_reg[2:0]); // [R5] [R6]
  wire logic tmr_wr     = wr & hit_tmr;
  wire logic t_wrap     = t_step & ~tmr_wr & (timer_reg == TIMER_MAX);         // [R22]

  // watchdog
  wire logic w_clear    = instr.wdog_clear_instr | instr.sleep_instr;           // [R16]
  wire logic w_step     = prescale_tick(wpres_reg, wdc_reg[WDC_PEN], wdc_reg[2:0]); // [R10] [R11]
  wire logic w_timeout  = wdc_reg[WDC_EN] & w_step &
                          (wcnt_reg == WDOG_TIMEOUT - 1'b1) & ~w_clear;         // [R20] [R21]

  // external interrupt pin
  wire logic epin_sel   = wdc_reg[WDC_PINSEL];
  wire logic epin_edge  = ctl_reg[CTL_EXT_EDGE] ?
                          (~ext_irq_shared_pin & epin_prev_reg) :
                          (ext_irq_shared_pin & ~epin_prev_reg);                // [R1]
  wire logic ext_event  = epin_sel & epin_edge;                                 // [R8]

  wire logic [7:0] set_v = {events.comparator_irq_flag, events.adc_done_irq_flag,
                            events.timer3_irq_flag, events.timer2_irq_flag, 1'b0,
                            ext_event, events.pin_change_irq_flag, t_wrap};
  wire logic [7:0] en_v  = {msk1_reg[FLG_COMP], msk1_reg[FLG_ADC], msk2_reg[FLG_T3],
                            msk2_reg[FLG_T2], 1'b0, msk1_reg[FLG_EXT],
                            msk1_reg[FLG_PCHG], msk1_reg[FLG_TIMER]};           // [R12] [R13]
  wire logic [7:0] clr_v = (wr & hit_flg) ? wbyte : RST_BYTE;

  always_comb begin
    ctl_next   = (wr & hit_ctl)  ? (wbyte & CTL_WMASK)  : ctl_reg;
    wdc_next   = (wr & hit_wdc)  ? (wbyte & WDC_WMASK)  : wdc_reg;              // [R7]
    msk2_next  = (wr & hit_msk2) ? (wbyte & MSK2_WMASK) : msk2_reg;
    msk1_next  = (wr & hit_msk1) ? (wbyte & MSK1_WMASK) : msk1_reg;
    timer_next = tmr_wr ? wbyte : (t_step ? 8'(timer_reg + 8'h01) : timer_reg);
    tpres_next = tmr_wr ? RST_BYTE : (t_active ? 8'(tpres_reg + 8'h01) : tpres_reg); // [R15] [R14]
    wpres_next = w_clear | w_timeout ? RST_BYTE : 8'(wpres_reg + 8'h01);         // [R14] [R16]
    if (w_clear | w_timeout | ~wdc_reg[WDC_EN])
      wcnt_next = '0;                                                           // [R16]
    else
      wcnt_next = w_step ? WDOG_CNT_W'(wcnt_reg + 1'b1) : wcnt_reg;
    flag_next  = (flag_reg & ~clr_v) | set_v;                                   // [R22]
    if (instr.irq_on_instr | instr.irq_return_instr)
      gie_next = 1'b1;                                                          // [R2]
    else if (instr.irq_off_instr | instr.irq_entry)
      gie_next = 1'b0;                                                          // [R2]
    else
      gie_next = gie_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_reg        <= RST_BYTE;
      wdc_reg        <= RST_BYTE;
      msk2_reg       <= RST_BYTE;
      msk1_reg       <= RST_BYTE;
      timer_reg      <= RST_BYTE;
      tpres_reg      <= RST_BYTE;
      wpres_reg      <= RST_BYTE;
      wcnt_reg       <= '0;
      flag_reg       <= RST_BYTE;
      gie_reg        <= 1'b0;
      tpin_prev_reg  <= 1'b0;
      epin_prev_reg  <= 1'b0;
    end else begin
      ctl_reg        <= ctl_next;
      wdc_reg        <= wdc_next;
      msk2_reg       <= msk2_next;
      msk1_reg       <= msk1_next;
      timer_reg      <= timer_next;
      tpres_reg      <= tpres_next;
      wpres_reg      <= wpres_next;
      wcnt_reg       <= wcnt_next;
      flag_reg       <= flag_next;
      gie_reg        <= gie_next;
      tpin_prev_reg  <= timer_pin;
      epin_prev_reg  <= ext_irq_shared_pin;
    end
  end

  // outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg     <= '0;
      pready_reg     <= 1'b0;
      pslverr_reg    <= 1'b0;
      irq_req_reg    <= 1'b0;
      wdog_reset_reg <= 1'b0;
      sleep_reg      <= 1'b0;
      ext_level_reg  <= 1'b0;
    end else begin
      prdata_reg     <= setup_ph ? {24'h000000, rbyte} : prdata_reg;
      pready_reg     <= setup_ph;
      pslverr_reg    <= setup_ph & ~mapped;
      irq_req_reg    <= gie_reg & |(flag_reg & en_v);                           // [R2] [R22]
      wdog_reset_reg <= w_timeout;                                              // [R20]
      sleep_reg      <= instr.sleep_instr | (sleep_reg & ~wake_req & ~w_timeout);
      ext_level_reg  <= epin_sel & ext_irq_shared_pin;                          // [R8]
    end
  end

  assign prdata        = prdata_reg;
  assign pready        = pready_reg;
  assign pslverr       = pslverr_reg;
  assign irq_req       = irq_req_reg;
  assign wdog_reset    = wdog_reset_reg;
  assign sleeping      = sleep_reg;
  assign ext_pin_level = ext_level_reg;

  // checks
  property p_ext_rise;
    @(posedge pclk) disable iff (!presetn)
    (epin_sel && !ctl_reg[CTL_EXT_EDGE] && ext_irq_shared_pin && !epin_prev_reg)
      |=> flag_reg[FLG_EXT];
  endproperty
  a_ext_rise: assert property (p_ext_rise) else $error("ext rise not flagged"); // [R1]

  property p_gie_off;
    @(posedge pclk) disable iff (!presetn)
    (instr.irq_off_instr && !instr.irq_on_instr && !instr.irq_return_instr)
      |=> !gie_reg ##1 !irq_req;
  endproperty
  a_gie_off: assert property (p_gie_off) else $error("irq not masked"); // [R2]

  property p_pin_count;
    @(posedge pclk) disable iff (!presetn)
    (ctl_reg[CTL_SRC] && !ctl_reg[CTL_TEDGE] && !ctl_reg[CTL_PEN] && !sleep_reg
     && !tmr_wr && timer_pin && !tpin_prev_reg) |=> timer_reg == 8'($past(timer_reg) + 8'h01);
  endproperty
  a_pin_count: assert property (p_pin_count) else $error("pin edge not counted"); // [R3]

  property p_pin_hold;
    @(posedge pclk) disable iff (!presetn)
    (ctl_reg[CTL_SRC] && !tmr_wr && (timer_pin == tpin_prev_reg)) |=> $stable(timer_reg);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("count without edge"); // [R4]

  property p_unscaled;
    @(posedge pclk) disable iff (!presetn)
    (!ctl_reg[CTL_SRC] && !ctl_reg[CTL_PEN] && !sleep_reg && !tmr_wr)
      |=> timer_reg == 8'($past(timer_reg) + 8'h01);
  endproperty
  a_unscaled: assert property (p_unscaled) else $error("1:1 rate broken"); // [R5]

  property p_div2;
    @(posedge pclk) disable iff (!presetn)
    (!ctl_reg[CTL_SRC] && ctl_reg[CTL_PEN] && ctl_reg[2:0] == 3'h0 && !sleep_reg
     && !tmr_wr && !tpres_reg[0]) |=> $stable(timer_reg);
  endproperty
  a_div2: assert property (p_div2) else $error("1:2 rate broken"); // [R6]

  property p_tmr_wr;
    @(posedge pclk) disable iff (!presetn)
    tmr_wr |=> tpres_reg == RST_BYTE && timer_reg == $past(wbyte);
  endproperty
  a_tmr_wr: assert property (p_tmr_wr) else $error("timer write side effect"); // [R15]

  property p_wclr;
    @(posedge pclk) disable iff (!presetn)
    w_clear |=> wcnt_reg == '0 && wpres_reg == RST_BYTE && !wdog_reset;
  endproperty
  a_wclr: assert property (p_wclr) else $error("watchdog not cleared"); // [R16]

  property p_sleep_stop;
    @(posedge pclk) disable iff (!presetn)
    (sleep_reg && !tmr_wr) |=> $stable(timer_reg);
  endproperty
  a_sleep_stop: assert property (p_sleep_stop) else $error("timer ran asleep"); // [R19]

  property p_wdog_off;
    @(posedge pclk) disable iff (!presetn)
    !wdc_reg[WDC_EN] |=> !wdog_reset;
  endproperty
  a_wdog_off: assert property (p_wdog_off) else $error("disabled watchdog fired"); // [R7]

  property p_wrap;
    @(posedge pclk) disable iff (!presetn)
    t_wrap |=> flag_reg[FLG_TIMER] && timer_reg == RST_BYTE
      ##1 (irq_req == ($past(gie_reg) && $past(msk1_reg[FLG_TIMER])));
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag or request wrong"); // [R22]

  property p_ext_fall;
    @(posedge pclk) disable iff (!presetn)
    (epin_sel && ctl_reg[CTL_EXT_EDGE] && !ext_irq_shared_pin && epin_prev_reg)
      |=> flag_reg[FLG_EXT];
  endproperty
  a_ext_fall: assert property (p_ext_fall) else $error("ext fall not flagged"); // [R1]

  property p_gie_on;
    @(posedge pclk) disable iff (!presetn)
    (instr.irq_on_instr || instr.irq_return_instr)
      |=> gie_reg;
  endproperty
  a_gie_on: assert property (p_gie_on) else $error("irq not enabled"); // [R2]

  property p_pin_masked;
    @(posedge pclk) disable iff (!presetn)
    (!epin_sel && !flag_reg[FLG_EXT])
      |=> !flag_reg[FLG_EXT] && !ext_pin_level;
  endproperty
  a_pin_masked: assert property (p_pin_masked) else $error("ext path not masked"); // [R8]

  property p_pin_level;
    @(posedge pclk) disable iff (!presetn)
    epin_sel
      |=> ext_pin_level == $past(ext_irq_shared_pin);
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level not readable"); // [R8]

  property p_wdog_unscaled;
    @(posedge pclk) disable iff (!presetn)
    (wdc_reg[WDC_EN] && !wdc_reg[WDC_PEN] && !w_clear && !w_timeout)
      |=> wcnt_reg == WDOG_CNT_W'($past(wcnt_reg) + 1'b1);
  endproperty
  a_wdog_unscaled: assert property (p_wdog_unscaled) else $error("wdog 1:1 broken"); // [R10]

  property p_wdog_div2;
    @(posedge pclk) disable iff (!presetn)
    (wdc_reg[WDC_EN] && wdc_reg[WDC_PEN] && wdc_reg[2:0] == 3'h0
     && !w_clear && !wpres_reg[0])
      |=> $stable(wcnt_reg);
  endproperty
  a_wdog_div2: assert property (p_wdog_div2) else $error("wdog 1:2 broken"); // [R11]

  property p_wpres_run;
    @(posedge pclk) disable iff (!presetn)
    (!w_clear && !w_timeout)
      |=> wpres_reg == 8'($past(wpres_reg) + 8'h01);
  endproperty
  a_wpres_run: assert property (p_wpres_run) else $error("wdog prescaler stalled"); // [R14]

  property p_tpres_hold;
    @(posedge pclk) disable iff (!presetn)
    (!tmr_wr && !t_active)
      |=> $stable(tpres_reg);
  endproperty
  a_tpres_hold: assert property (p_tpres_hold) else $error("timer prescaler ran idle"); // [R14]

  property p_internal_src;
    @(posedge pclk) disable iff (!presetn)
    (!ctl_reg[CTL_SRC] && !sleep_reg && !tmr_wr)
      |=> tpres_reg == 8'($past(tpres_reg) + 8'h01);
  endproperty
  a_internal_src: assert property (p_internal_src) else $error("core cycle missed"); // [R17]

  property p_mask_block;
    @(posedge pclk) disable iff (!presetn)
    ((flag_reg & en_v) == RST_BYTE)
      |=> !irq_req;
  endproperty
  a_mask_block: assert property (p_mask_block) else $error("masked source raised irq"); // [R13]

  property p_timeout_wake;
    @(posedge pclk) disable iff (!presetn)
    w_timeout
      |=> wdog_reset && !sleeping;
  endproperty
  a_timeout_wake: assert property (p_timeout_wake) else $error("timeout did not reset"); // [R20]

  property p_timeout_count;
    @(posedge pclk) disable iff (!presetn)
    wdog_reset
      |-> $past(wcnt_reg) == WDOG_CNT_W'(WDOG_TIMEOUT - 1'b1);
  endproperty
  a_timeout_count: assert property (p_timeout_count) else $error("early timeout"); // [R21]

  c_wrap:    cover property (@(posedge pclk) disable iff (!presetn) t_wrap);
  c_timeout: cover property (@(posedge pclk) disable iff (!presetn) w_timeout);
  c_ext_irq: cover property (@(posedge pclk) disable iff (!presetn)
                             flag_reg[FLG_EXT] && irq_req);
  c_err:     cover property (@(posedge pclk) disable iff (!presetn) pslverr && pready);
  c_wake:    cover property (@(posedge pclk) disable iff (!presetn) sleep_reg && w_timeout);

endmodule : tw_timer_wdog

// ---- bench/tw_core_model.sv ----
/* tw_core_model: the processor core, as APB master and instruction source.
   assumes pclk runs freely and the bench owns reset and the pins. */
`timescale 1ns/1ps
module tw_core_model
  import tw_pkg::*;
(
  input  wire logic         pclk,
  output logic              psel,
  output logic              penable,
  output logic              pwrite,
  output logic [7:0]        paddr,
  output logic [31:0]       pwdata,
  input  wire logic         pready,
  output tw_core_instr_type instr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    instr = '0;
  end
  // setup, access held until pready, then an idle edge
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  // one-cycle instruction pulse; pin direction left to software
  task automatic pulse(input logic [5:0] i);
    instr <= tw_core_instr_type'(i);
    @(posedge pclk);
    instr <= '0;
  endtask : pulse
endmodule : tw_core_model

// ---- bench/tb_top.sv ----
/* tb_top: self-checking bench for tw_timer_wdog; reads checked from a queue.
   assumes tw_core_model as core and a 20-cycle watchdog time-out. */
`timescale 1ns/1ps
module tb_top
  import tw_pkg::*;
;
  localparam int WT = 20;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [7:0]        paddr;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  tw_core_instr_type instr;
  tw_event_type      events = '0;
  logic              wake_req = 1'b0;
  logic              timer_pin = 1'b0;
  logic              ext_pin = 1'b0;
  logic              ext_pin_level;
  logic              irq_req;
  logic              wdog_reset;
  logic              sleeping;
  logic [32:0]       exp_q[$];
  logic [32:0]       exp_v;
  logic [31:0]       d;
  int                num_errors = 0;
  int                check_count = 0;
  int                wd_cnt = 0;
  int                n;
  logic [7:0]        wm[4] = '{CTL_WMASK, WDC_WMASK, MSK2_WMASK, MSK1_WMASK};
  int                fb[5] = '{7, 6, 5, 4, 1};

  always #20 pclk = ~pclk;

  tw_core_model tw_core_model_i (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .instr(instr));
  tw_timer_wdog #(.WDOG_TIMEOUT(WDOG_CNT_W'(WT))) tw_timer_wdog_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr(instr),
    .events(events), .wake_req(wake_req), .timer_pin(timer_pin),
    .ext_irq_shared_pin(ext_pin), .ext_pin_level(ext_pin_level), .irq_req(irq_req),
    .wdog_reset(wdog_reset), .sleeping(sleeping));

  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic test_done;
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    tw_core_model_i.xfer(1'b0, a, 32'h0);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    tw_core_model_i.xfer(1'b1, a, {24'h0, v});
  endtask : wr
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask : cyc
  // each level held two cycles
  task automatic pins(input int k);
    repeat (k) begin
      timer_pin <= 1'b1;
      cyc(2);
      timer_pin <= 1'b0;
      cyc(2);
    end
  endtask : pins
  // cycles between two watchdog pulses
  task automatic wd_gap(output int k);
    int g;
    g = 0;
    while (wdog_reset !== 1'b1 && g < 5000) begin
      @(posedge pclk);
      g++;
    end
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (wdog_reset !== 1'b1 && k < 5000);
  endtask : wd_gap

  always @(posedge pclk) begin
    if (wdog_reset === 1'b1) wd_cnt++;
    if (psel && penable && pready && !pwrite) begin
      exp_v = exp_q.pop_front();
      chk({pslverr, prdata}, exp_v);
    end
  end

  initial begin
    #800000;
    num_errors++;
    test_done();
  end

  initial begin
    void'($urandom(32'h211d));
    cyc(5);
    presetn <= 1'b1;
    cyc(1);
    // timer free-runs from reset: 13 edges before its setup edge
    for (int i = 0; i < 6; i++) rd(8'(4 * i), (i == 4) ? 33'h0D : 33'h0);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      wr(8'(4 * i), d[7:0]);
      rd(8'(4 * i), {25'h0, d[7:0] & wm[i]});
    end
    rd(8'h18, {1'b1, 32'h0});
    wr(8'h04, 8'h00);
    wr(8'h00, 8'h20);
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'h00);
    wr(8'h14, 8'hFF);
    rd(8'h14, 33'h0);
    for (int i = 0; i < 4; i++) begin
      tw_core_model_i.pulse(6'h20 >> i);
      rd(8'h00, (i % 2) ? 33'h20 : 33'h60);
    end
    for (int e = 0; e < 2; e++) begin
      wr(8'h00, 8'(8'h20 | (e << 4)));
      wr(8'h10, 8'h00);
      timer_pin <= 1'b1;
      cyc(3);
      rd(8'h10, (e == 1) ? 33'h0 : 33'h1);
      timer_pin <= 1'b0;
      cyc(3);
      rd(8'h10, 33'h1);
    end
    for (int r = 0; r < 8; r++) begin
      wr(8'h00, 8'(8'h28 | r));
      pins(1);
      wr(8'h10, 8'h00);
      pins(3 << (r + 1));
      rd(8'h10, 33'h3);
    end
    wr(8'h00, 8'h00);
    tw_core_model_i.pulse(6'h01);
    wr(8'h10, 8'h5A);
    cyc(9);
    rd(8'h10, 33'h5A);
    chk(33'(sleeping), 33'h1);
    wake_req <= 1'b1;
    cyc(1);
    wake_req <= 1'b0;
    wr(8'h00, 8'h20);
    wr(8'h14, 8'hFF);
    tw_core_model_i.pulse(6'h20);
    wr(8'h0C, 8'h01);
    wr(8'h10, 8'hFF);
    pins(1);
    rd(8'h14, 33'h1);
    chk(33'(irq_req), 33'h1);
    wr(8'h14, 8'h01);
    cyc(3);
    chk(33'(irq_req), 33'h0);
    wr(8'h0C, 8'h00);
    for (int k = 0; k < 5; k++) begin
      events <= tw_event_type'(5'h10 >> k);
      cyc(1);
      events <= '0;
      rd(8'h14, 33'(1 << fb[k]));
      chk(33'(irq_req), 33'h0);
      wr((fb[k] == 4 || fb[k] == 5) ? 8'h08 : 8'h0C, 8'(1 << fb[k]));
      cyc(3);
      chk(33'(irq_req), 33'h1);
      tw_core_model_i.pulse(6'h10);
      cyc(3);
      chk(33'(irq_req), 33'h0);
      tw_core_model_i.pulse(6'h20);
      wr(8'h08, 8'h00);
      wr(8'h0C, 8'h00);
      wr(8'h14, 8'hFF);
    end
    ext_pin <= 1'b1;
    cyc(3);
    chk(33'(ext_pin_level), 33'h0);
    ext_pin <= 1'b0;
    cyc(3);
    rd(8'h14, 33'h0);
    wr(8'h04, 8'h40);
    for (int e = 0; e < 2; e++) begin
      wr(8'h00, 8'(8'h20 | (e << 7)));
      wr(8'h14, 8'hFF);
      ext_pin <= 1'b1;
      cyc(3);
      chk(33'(ext_pin_level), 33'h1);
      rd(8'h14, (e == 1) ? 33'h0 : 33'h4);
      ext_pin <= 1'b0;
      cyc(3);
      rd(8'h14, 33'h4);
    end
    for (int r = 0; r < 4; r++) begin
      wr(8'h04, (r == 0) ? 8'h80 : 8'(8'h88 | (r - 1)));
      wd_gap(n);
      chk(33'(n), 33'(WT << r));
    end
    wr(8'h04, 8'h80);
    n = wd_cnt;
    for (int i = 0; i < 16; i++) begin
      tw_core_model_i.pulse((i % 2) ? 6'h01 : 6'h02);
      cyc(9);
    end
    chk(33'(wd_cnt), 33'(n));
    cyc(25);
    chk(33'(wd_cnt), 33'(n + 1));
    chk(33'(sleeping), 33'h0);
    wr(8'h04, 8'h00);
    cyc(60);
    chk(33'(wd_cnt), 33'(n + 1));
    test_done();
  end
endmodule : tb_top
